// *** design/spo_cmp.sv ***
// spo_cmp: turn-on and turn-off trigger decision for one setpoint
// assumes: settings stable while a new display value is presented
`timescale 1ns/100ps
`default_nettype none
module spo_cmp
  import spo_pkg::*;
(
  spo_cmp_if.cmp c
);
  logic signed [19:0] v;
  logic signed [19:0] sp;
  logic signed [19:0] hy;
  logic signed [19:0] half;
  logic signed [19:0] rest;

  // balanced splits the band around the setpoint, unbalanced keeps it on one side
  always_comb begin
    v    = {{2{c.val[17]}}, c.val};
    sp   = {{2{c.sp[17]}}, c.sp};
    hy   = {4'h0, c.hys};
    half = {5'h00, c.hys[15:1]};
    rest = hy - half;
    unique case (c.act)
      high_balanced_action: begin   // R1
        c.on_c  = v >= sp + half;
        c.off_c = v <= sp - rest;
      end
      low_balanced_action: begin
        c.on_c  = v <= sp - rest;
        c.off_c = v >= sp + half;
      end
      high_unbalanced_action: begin // R4
        c.on_c  = v >= sp;
        c.off_c = v <= sp - hy;
      end
      low_unbalanced_action: begin  // R4
        c.on_c  = v <= sp;
        c.off_c = v >= sp + hy;
      end
    endcase
  end
endmodule
`default_nettype wire

// *** design/spo_cmp_if.sv ***
// spo_cmp_if: carries one setpoint's settings to its comparator and the trigger results back
// assumes: one instance per setpoint inside spo_top
`timescale 1ns/100ps
`default_nettype none
interface spo_cmp_if;
  import spo_pkg::*;
  spo_val_t    val;
  spo_val_t    sp;
  logic [15:0] hys;
  spo_action_t act;
  logic        on_c;
  logic        off_c;
  modport cmp (input val, sp, hys, act, output on_c, off_c);
  modport usr (output val, sp, hys, act, input on_c, off_c);
endinterface
`default_nettype wire

// *** design/spo_consts.svh ***
// spo_consts.svh: register map, field positions, limits, reset values and timing counts
// assumes: included by bare name from the setpoint output design files
`ifndef SPO_CONSTS_SVH
`define SPO_CONSTS_SVH
// register byte addresses and per-channel layout
`define SPO_A_CTRL   8'h00
`define SPO_A_CH0    8'h04
`define SPO_CH_SPAN  8'h18
`define SPO_O_CFG    8'h00
`define SPO_O_VAL    8'h04
`define SPO_O_HYS    8'h08
`define SPO_O_TON    8'h0C
`define SPO_O_TOFF   8'h10
`define SPO_A_STAT   8'h34
`define SPO_A_CMD    8'h38
// control register fields
`define SPO_C_SP2EN  0
`define SPO_C_BTNDSP 1
`define SPO_C_BACKLT 2
`define SPO_C_UIF    4
// per-channel configuration fields
`define SPO_F_ACT    0
`define SPO_F_MODE   2
`define SPO_F_RWD    4
`define SPO_F_STBY   5
`define SPO_F_BURN   6
`define SPO_F_COLOR  7
// value limits
`define SPO_SP_MIN   (-9999)
`define SPO_SP_MAX   99999
`define SPO_HYS_MIN  1
`define SPO_HYS_MAX  59999
`define SPO_DLY_MAX  5999
// reset values
`define SPO_CTRL_RST 8'h00
`define SPO_CFG_RST  8'h00
`define SPO_HYS_RST  16'h0001
// timing: delay base is one second of the 25 MHz clock
`define SPO_CLK_HZ   25000000
`define SPO_TICK_S   1
`define SPO_SEC_CYC  (`SPO_CLK_HZ * `SPO_TICK_S)
`endif

// *** design/spo_pkg.sv ***
// spo_pkg: types shared by the setpoint output block
// assumes: compiled before every other design file
package spo_pkg;
  typedef logic signed [17:0] spo_val_t;
  typedef enum logic [1:0] {
    high_balanced_action, low_balanced_action,
    high_unbalanced_action, low_unbalanced_action
  } spo_action_t;
  typedef enum logic [1:0] {
    auto_reset_mode, latch_immediate_reset_mode,
    latch_delayed_reset_mode, spare_reset_mode
  } spo_rmode_t;
  typedef enum logic [2:0] {
    no_input_function, reset_output_one, reset_output_two,
    reset_both_outputs, display_value_assignment
  } spo_uif_t;
  typedef enum logic [1:0] {
    st_off, st_wait_on, st_on, st_wait_off
  } spo_state_t;
endpackage

// *** design/spo_tick.sv ***
// spo_tick: divides the system clock down to a one-cycle pulse per second
// assumes: DIV is the number of clock cycles in one second
`timescale 1ns/100ps
`default_nettype none
`include "spo_consts.svh"
module spo_tick #(
  parameter int unsigned DIV = `SPO_SEC_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);
  localparam int W = $clog2(DIV > 1 ? DIV : 2);
  logic [W-1:0] cnt_q;

  // free-running divider, pulse on wrap
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (cnt_q == W'(DIV - 1)) begin
      cnt_q <= '0;
      tick  <= 1'b1; // R21
    end else begin
      cnt_q <= cnt_q + W'(1);
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** design/spo_top.sv ***
// spo_top: two setpoint outputs of a panel meter with apb register access
// assumes: inputs synchronous to clk; value_valid pulses once per new display value
//
// Behaviour
// R1: each output is high or low acting, balanced or unbalanced hysteresis
// R2: setpoint is signed, -9999 to 99999, display decimal point
// R3: hysteresis is programmable from 1 to 59999 counts
// R4: unbalanced band lies below setpoint for high, above for low acting
// R5: on delay of 0 to 5999 s after the turn-on trigger
// R6: off delay of 0 to 5999 s after the turn-off trigger
// R7: zero delay means update at the measurement rate
// R8: automatic mode turns off at triggers; manual reset forces off until recrossed
// R9: latching modes latch on; only manual, serial reset or power cycle clears
// R10: immediate latch reset clears at once, stays off until recrossed
// R11: after power-up a latched output is off
// R12: delayed latch reset is held pending until the turn-off trigger
// R13: pending delayed reset is lost at power cycle unless asserted then
// R14: display reset also resets the output when enabled and input shown
// R15: standby keeps output off after power-up until trigger first crossed
// R16: open probe forces each output to its programmed burn-out state
// R17: backlight colour toggles when an enabled output changes state
// R18: second output runs only when its enable is set
// R19: setpoints inactive without a card; card decides one or two
// R20: user input resets output one, two or both per its function
// R21: evaluation per new value, delays counted in whole seconds
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "spo_consts.svh"
module spo_top
  import spo_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `SPO_SEC_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire spo_val_t    disp_value,
  input  wire logic        value_valid,
  input  wire logic        probe_open,
  input  wire logic        card_present,
  input  wire logic        card_dual,
  input  wire logic        btn_reset,
  input  wire logic        user_input,
  input  wire logic        input_shown,
  output logic [1:0]       sp_out,
  output logic             color_alt
);
  logic [7:0]  ctrl_q;
  logic [7:0]  cfg_q  [2];
  spo_val_t    sp_q   [2];
  logic [15:0] hys_q  [2];
  logic [12:0] ton_q  [2];
  logic [12:0] toff_q [2];
  logic [12:0] cnt_q  [2];
  spo_state_t  st_q   [2];
  logic [1:0]  out_q;
  logic [1:0]  prev_q;
  logic [1:0]  hold_q;
  logic [1:0]  pend_q;
  logic [1:0]  stby_q;
  logic [1:0]  ser_q;
  logic        color_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  logic        tick;
  logic        map_hit;
  logic        wr_en;
  logic        disp_rst;
  logic        btn_direct;
  spo_uif_t    uif;
  wire logic [1:0] ch_hit;
  wire logic [7:0] ch_off [2];
  wire logic [1:0] on_c;
  wire logic [1:0] off_c;
  logic [1:0]  en;
  logic [1:0]  mres;
  logic [1:0]  uif_hit;
  logic [1:0]  stby_act;
  logic [1:0]  dly;
  logic [1:0]  auto_m;
  logic [1:0]  chg;

  // write clamps keep stored settings inside the legal ranges
  function automatic spo_val_t clamp_sp(input logic [31:0] w);
    logic signed [31:0] s;
    s = $signed(w);
    if (s < `SPO_SP_MIN) return 18'(`SPO_SP_MIN);
    if (s > `SPO_SP_MAX) return 18'(`SPO_SP_MAX);
    return s[17:0];
  endfunction

  function automatic logic [15:0] clamp_hys(input logic [31:0] w);
    if (w < `SPO_HYS_MIN) return 16'(`SPO_HYS_MIN);
    if (w > `SPO_HYS_MAX) return 16'(`SPO_HYS_MAX);
    return w[15:0];
  endfunction

  function automatic logic [12:0] clamp_dly(input logic [31:0] w);
    if (w > `SPO_DLY_MAX) return 13'(`SPO_DLY_MAX);
    return w[12:0];
  endfunction

  spo_tick #(.DIV(SEC_CYCLES)) u_tick (
    .clk  (clk),
    .rst  (rst),
    .tick (tick)
  );

  // per-channel address decode and comparator
  for (genvar i = 0; i < 2; i++) begin : g_ch
    localparam logic [7:0] BASE = 8'(`SPO_A_CH0 + i * `SPO_CH_SPAN);
    spo_cmp_if cif ();
    assign ch_off[i] = paddr - BASE;
    assign ch_hit[i] = (paddr >= BASE) && (ch_off[i] <= `SPO_O_TOFF) && (paddr[1:0] == 2'b00);
    assign cif.val   = disp_value;
    assign cif.sp    = sp_q[i];
    assign cif.hys   = hys_q[i];
    assign cif.act   = spo_action_t'(cfg_q[i][`SPO_F_ACT +: 2]);
    assign on_c[i]   = cif.on_c;
    assign off_c[i]  = cif.off_c;
    spo_cmp u_cmp (
      .c (cif)
    );
  end

  // apb slave: zero wait states, error on unmapped words
  assign map_hit = (paddr == `SPO_A_CTRL) || (paddr == `SPO_A_STAT) ||
                   (paddr == `SPO_A_CMD) || (|ch_hit);
  assign wr_en   = psel & penable & pwrite & map_hit;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~map_hit;
  assign prdata  = prdata_q;

  // read multiplexer
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr == `SPO_A_CTRL) rd_mux = {24'h00_0000, ctrl_q};
    if (paddr == `SPO_A_STAT) begin
      rd_mux = {24'h00_0000, card_present, color_q, stby_act, pend_q, out_q};
    end
    for (int k = 0; k < 2; k++) begin
      if (ch_hit[k]) begin
        case (ch_off[k])
          `SPO_O_CFG:  rd_mux = {24'h00_0000, cfg_q[k]};
          `SPO_O_VAL:  rd_mux = {{14{sp_q[k][17]}}, sp_q[k]};
          `SPO_O_HYS:  rd_mux = {16'h0000, hys_q[k]};
          `SPO_O_TON:  rd_mux = {19'h0_0000, ton_q[k]};
          `SPO_O_TOFF: rd_mux = {19'h0_0000, toff_q[k]};
          default:     rd_mux = 32'h0000_0000;
        endcase
      end
    end
  end

  // read data captured in the setup phase
  always_ff @(posedge clk) begin
    if (rst) prdata_q <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata_q <= rd_mux;
  end

  // control and setpoint registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= `SPO_CTRL_RST;
      for (int k = 0; k < 2; k++) begin
        cfg_q[k]  <= `SPO_CFG_RST;
        sp_q[k]   <= '0;
        hys_q[k]  <= `SPO_HYS_RST;
        ton_q[k]  <= '0;
        toff_q[k] <= '0;
      end
    end else if (wr_en) begin
      if (paddr == `SPO_A_CTRL) ctrl_q <= pwdata[7:0];
      for (int k = 0; k < 2; k++) begin
        if (ch_hit[k]) begin
          case (ch_off[k])
            `SPO_O_CFG:  cfg_q[k]  <= pwdata[7:0];
            `SPO_O_VAL:  sp_q[k]   <= clamp_sp(pwdata);  // R2
            `SPO_O_HYS:  hys_q[k]  <= clamp_hys(pwdata); // R3
            `SPO_O_TON:  ton_q[k]  <= clamp_dly(pwdata); // R5
            `SPO_O_TOFF: toff_q[k] <= clamp_dly(pwdata); // R6
            default:     ;
          endcase
        end
      end
    end
  end

  // serial reset command, one-cycle pulse per written bit
  always_ff @(posedge clk) begin
    if (rst) ser_q <= 2'b00;
    else ser_q <= (wr_en && paddr == `SPO_A_CMD) ? pwdata[1:0] : 2'b00;
  end

  // enables, reset sources and mode decode
  assign uif        = spo_uif_t'(ctrl_q[`SPO_C_UIF +: 3]);
  assign btn_direct = btn_reset & ~ctrl_q[`SPO_C_BTNDSP];
  assign disp_rst   = input_shown & ((btn_reset & ctrl_q[`SPO_C_BTNDSP]) |
                      (user_input & (uif == display_value_assignment)));       // R14
  assign uif_hit[0] = user_input & (uif == reset_output_one || uif == reset_both_outputs); // R20
  assign uif_hit[1] = user_input & (uif == reset_output_two || uif == reset_both_outputs); // R20
  assign en[0]      = card_present;                                            // R19
  assign en[1]      = card_present & card_dual & ctrl_q[`SPO_C_SP2EN];         // R18

  always_comb begin
    for (int k = 0; k < 2; k++) begin
      mres[k]     = btn_direct | uif_hit[k] | ser_q[k] |
                    (disp_rst & cfg_q[k][`SPO_F_RWD]);                         // R14
      dly[k]      = cfg_q[k][`SPO_F_MODE +: 2] == latch_delayed_reset_mode;
      auto_m[k]   = cfg_q[k][`SPO_F_MODE +: 2] == auto_reset_mode ||
                    cfg_q[k][`SPO_F_MODE +: 2] == spare_reset_mode;
      stby_act[k] = stby_q[k] & cfg_q[k][`SPO_F_STBY];                         // R15
      chg[k]      = (out_q[k] != prev_q[k]) & cfg_q[k][`SPO_F_COLOR];
    end
  end

  // output state machines, evaluated on each new value and each second
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int k = 0; k < 2; k++) begin
        st_q[k]  <= st_off;
        cnt_q[k] <= '0;
      end
      out_q  <= 2'b00; // R11
      hold_q <= 2'b00;
      pend_q <= 2'b00; // R13
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (!en[k]) begin
          st_q[k]   <= st_off; // R18 R19
          out_q[k]  <= 1'b0;
          cnt_q[k]  <= '0;
          hold_q[k] <= 1'b0;
          pend_q[k] <= 1'b0;
        end else if (probe_open) begin
          out_q[k] <= cfg_q[k][`SPO_F_BURN]; // R16
        end else if (mres[k] && !dly[k]) begin
          st_q[k]   <= st_off; // R8 R10
          out_q[k]  <= 1'b0;
          cnt_q[k]  <= '0;
          hold_q[k] <= on_c[k]; // hold off only while the value sits in the on region
        end else begin
          if (mres[k]) pend_q[k] <= 1'b1; // R12 R13
          if (value_valid && !on_c[k]) hold_q[k] <= 1'b0;
          unique case (st_q[k])
            st_off: begin
              out_q[k] <= 1'b0;
              if (value_valid && on_c[k] && !hold_q[k] && !stby_act[k]) begin // R21
                if (ton_q[k] == '0) begin
                  st_q[k]  <= st_on; // R7
                  out_q[k] <= 1'b1;
                end else begin
                  st_q[k]  <= st_wait_on;
                  cnt_q[k] <= '0;
                end
              end
            end
            st_wait_on: begin
              out_q[k] <= 1'b0; // drop a burn-out level left from an open probe
              if (value_valid && !on_c[k]) st_q[k] <= st_off;
              else if (tick) begin
                if (13'(cnt_q[k] + 13'h1) >= ton_q[k]) begin
                  st_q[k]  <= st_on; // R5
                  out_q[k] <= 1'b1;
                end else cnt_q[k] <= cnt_q[k] + 13'h1;
              end
            end
            st_on: begin
              out_q[k] <= 1'b1; // R9
              if (value_valid && off_c[k]) begin
                if (auto_m[k]) begin
                  if (toff_q[k] == '0) begin
                    st_q[k]  <= st_off; // R7 R8
                    out_q[k] <= 1'b0;
                  end else begin
                    st_q[k]  <= st_wait_off;
                    cnt_q[k] <= '0;
                  end
                end else if (dly[k] && (pend_q[k] || mres[k])) begin
                  st_q[k]   <= st_off; // R12
                  out_q[k]  <= 1'b0;
                  pend_q[k] <= 1'b0;
                end
              end
            end
            st_wait_off: begin
              out_q[k] <= 1'b1; // output stays on while the off delay runs
              if (value_valid && !off_c[k]) st_q[k] <= st_on;
              else if (tick) begin
                if (13'(cnt_q[k] + 13'h1) >= toff_q[k]) begin
                  st_q[k]  <= st_off; // R6
                  out_q[k] <= 1'b0;
                end else cnt_q[k] <= cnt_q[k] + 13'h1;
              end
            end
          endcase
        end
      end
    end
  end

  // standby clears once the value has left the turn-on region
  always_ff @(posedge clk) begin
    if (rst) stby_q <= 2'b11;
    else begin
      for (int k = 0; k < 2; k++) begin
        if (value_valid && !on_c[k]) stby_q[k] <= 1'b0; // R15
      end
    end
  end

  // backlight colour follows output changes on backlit units
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q  <= 2'b00;
      color_q <= 1'b0;
    end else begin
      prev_q <= out_q;
      if (ctrl_q[`SPO_C_BACKLT] && (chg[0] ^ chg[1])) color_q <= ~color_q; // R17
    end
  end

  assign sp_out    = out_q;
  assign color_alt = color_q;

  // checks on channel one, the second output enable and shared outputs
  AST_NO_CARD: assert property (@(posedge clk) disable iff (rst) // R19
    !card_present |=> sp_out == 2'b00) else $error("output on without card");
  AST_SP2_OFF: assert property (@(posedge clk) disable iff (rst) // R18
    !ctrl_q[`SPO_C_SP2EN] |=> !sp_out[1]) else $error("second output on while disabled");
  AST_BURNOUT: assert property (@(posedge clk) disable iff (rst) // R16
    card_present && probe_open |=> sp_out[0] == $past(cfg_q[0][`SPO_F_BURN]))
    else $error("burn-out state not applied");
  AST_ZERO_DLY: assert property (@(posedge clk) disable iff (rst) // R7
    en[0] && !probe_open && !mres[0] && st_q[0] == st_off && value_valid && on_c[0] &&
    !hold_q[0] && !stby_act[0] && ton_q[0] == '0 |=> sp_out[0])
    else $error("zero on delay did not switch on");
  AST_AUTO_RST: assert property (@(posedge clk) disable iff (rst) // R8
    en[0] && !probe_open && mres[0] && auto_m[0] |=>
    !sp_out[0] && hold_q[0] == $past(on_c[0]))
    else $error("manual reset ignored in automatic mode");
  AST_IMM_RST: assert property (@(posedge clk) disable iff (rst) // R10
    en[0] && !probe_open && mres[0] && !dly[0] && sp_out[0] |=> !sp_out[0] ##1 !sp_out[0])
    else $error("latched output not cleared at once");
  AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (rst) // R9
    en[0] && card_present ##0 !probe_open && !auto_m[0] && st_q[0] == st_on && !mres[0] &&
    !pend_q[0] |=> sp_out[0]) else $error("latched output dropped");
  AST_DLY_PEND: assert property (@(posedge clk) disable iff (rst) // R12
    en[0] && !probe_open && dly[0] && mres[0] && !(value_valid && off_c[0]) |=>
    pend_q[0] || !sp_out[0]) else $error("delayed reset not held");
  AST_PWRUP: assert property (@(posedge clk) // R11
    $past(rst) |-> sp_out == 2'b00 && pend_q == 2'b00) else $error("state kept over power-up");
  AST_SP_RANGE: assert property (@(posedge clk) disable iff (rst) // R2
    sp_q[0] >= `SPO_SP_MIN && sp_q[0] <= `SPO_SP_MAX) else $error("setpoint out of range");
  AST_HYS_RANGE: assert property (@(posedge clk) disable iff (rst) // R3
    hys_q[0] >= `SPO_HYS_MIN && hys_q[0] <= `SPO_HYS_MAX) else $error("hysteresis out of range");
  AST_STBY: assert property (@(posedge clk) disable iff (rst) // R15
    stby_act[0] && st_q[0] == st_off && !probe_open |=> !sp_out[0])
    else $error("output left standby early");
  AST_ON_WAIT: assert property (@(posedge clk) disable iff (rst) // R5
    en[0] && !probe_open && st_q[0] == st_wait_on && !tick |=> !sp_out[0])
    else $error("on delay cut short");
  AST_OFF_WAIT: assert property (@(posedge clk) disable iff (rst) // R6
    en[0] && !probe_open && !mres[0] && st_q[0] == st_wait_off && !tick |=> sp_out[0])
    else $error("off delay cut short");
  AST_COLOR: assert property (@(posedge clk) disable iff (rst) // R17
    ctrl_q[`SPO_C_BACKLT] && chg[0] && !chg[1] |=> color_q != $past(color_q))
    else $error("colour did not toggle");
endmodule
`default_nettype wire

// *** test/spo_card_model.sv ***
// spo_card_model: behavioural setpoint output card that drives the external loads
// assumes: fit is set by the bench; sp_out comes from spo_top
`timescale 1ns/100ps
`default_nettype none
module spo_card_model (
  input  wire logic       clk,
  input  wire logic [1:0] fit,
  input  wire logic [1:0] sp_out,
  output logic            card_present,
  output logic            card_dual,
  output logic [1:0]      load_on
);
  // presence strap and channel count of the fitted card
  assign card_present = fit[0];
  assign card_dual    = fit[0] & fit[1];
  // relays follow the outputs only where a channel is fitted
  always_ff @(posedge clk) begin
    load_on <= sp_out & {card_dual, card_present};
  end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// tb_top: register and output sequences for the setpoint output block
// assumes: spo_pkg compiled first; one-second base shortened to 10 cycles
`timescale 1ns/100ps
`default_nettype none
`include "spo_consts.svh"
module tb_top
  import spo_pkg::*;
;
  localparam logic [7:0] A_CTRL = `SPO_A_CTRL;
  localparam logic [7:0] A_CFG  = `SPO_A_CH0 + `SPO_O_CFG;
  localparam logic [7:0] A_VAL  = `SPO_A_CH0 + `SPO_O_VAL;
  localparam logic [7:0] A_HYS  = `SPO_A_CH0 + `SPO_O_HYS;
  localparam logic [7:0] A_TON  = `SPO_A_CH0 + `SPO_O_TON;
  localparam logic [7:0] A_TOFF = `SPO_A_CH0 + `SPO_O_TOFF;
  localparam logic [7:0] A_VAL1 = `SPO_A_CH0 + `SPO_CH_SPAN + `SPO_O_VAL;
  localparam logic [7:0] A_HYS1 = `SPO_A_CH0 + `SPO_CH_SPAN + `SPO_O_HYS;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  spo_val_t    disp_value;
  logic        value_valid, probe_open, card_present, card_dual;
  logic        btn_reset, user_input, input_shown, color_alt;
  logic [1:0]  sp_out, fit, load_on;
  int          n_errors, n_compared;

  spo_top #(.SEC_CYCLES(10)) dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .disp_value(disp_value), .value_valid(value_valid),
    .probe_open(probe_open), .card_present(card_present), .card_dual(card_dual),
    .btn_reset(btn_reset), .user_input(user_input), .input_shown(input_shown),
    .sp_out(sp_out), .color_alt(color_alt));
  spo_card_model card (.clk(clk), .fit(fit), .sp_out(sp_out), .card_present(card_present),
    .card_dual(card_dual), .load_on(load_on));

  // compare one value and count it
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata   = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdata);
  endtask
  // present one new display value
  task automatic smp(input spo_val_t v);
    @(posedge clk);
    disp_value  <= v;
    value_valid <= 1'b1;
    @(posedge clk);
    value_valid <= 1'b0;
    @(negedge clk);
  endtask
  task automatic out(input int i, input logic e);
    chk("sp_out", 32'(e), 32'(sp_out[i]));
  endtask
  task automatic sc(input spo_val_t v, input logic e);
    smp(v);
    out(0, e);
  endtask
  // momentary front button or user input
  task automatic press(input logic b, input logic u);
    @(posedge clk);
    btn_reset  <= b;
    user_input <= u;
    @(posedge clk);
    btn_reset  <= 1'b0;
    user_input <= 1'b0;
    @(negedge clk);
  endtask
  // cycles until output one reaches e must fall in lo..hi
  task automatic dwait(input logic e, input int lo, input int hi);
    int n;
    n = 0;
    while (sp_out[0] !== e && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("delay cycles", 32'h1, 32'(lo <= n && n <= hi));
  endtask
  task automatic print_verdict();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // watchdog against a hung wait
  initial begin
    #400000;
    n_errors++;
    print_verdict();
  end
  // main sequence; setpoint 0x64 with hysteresis 0xA on output one
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {disp_value, value_valid, probe_open, btn_reset, user_input, input_shown} = 23'h0;
    fit = 2'b01;
    n_errors = 0;
    n_compared = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdc(A_CTRL, 32'h0, "ctrl reset");
    rdc(A_CFG, 32'h0, "cfg reset");
    rdc(A_HYS, 32'h1, "hys reset");
    rdc(8'hFC, 32'h0, "unmapped read");
    chk("unmapped err", 32'h1, 32'(rerr));
    apb(1'b1, A_HYS, 32'h0);
    rdc(A_HYS, 32'h1, "hys min");
    apb(1'b1, A_HYS, 32'h11170);
    rdc(A_HYS, 32'hEA5F, "hys max");
    apb(1'b1, A_VAL, 32'h186A0);
    rdc(A_VAL, 32'h1869F, "sp max");
    apb(1'b1, A_VAL, 32'hFFFFB1E0);
    rdc(A_VAL, 32'hFFFFD8F1, "sp min");
    apb(1'b1, A_TON, 32'h2328);
    rdc(A_TON, 32'h176F, "on delay max");
    apb(1'b1, A_TON, 32'h0);
    apb(1'b1, A_VAL, 32'h64);
    apb(1'b1, A_HYS, 32'hA);
    apb(1'b1, A_CTRL, 32'h14);
    apb(1'b1, A_CFG, 32'h80);
    sc(18'h68, 1'b0);
    sc(18'h69, 1'b1);
    @(negedge clk);
    chk("colour", 32'h1, 32'(color_alt));
    sc(18'h60, 1'b1);
    sc(18'h5F, 1'b0);
    @(negedge clk);
    chk("colour", 32'h0, 32'(color_alt));
    apb(1'b1, A_CFG, 32'h82);
    sc(18'h64, 1'b1);
    sc(18'h5B, 1'b1);
    sc(18'h5A, 1'b0);
    apb(1'b1, A_CFG, 32'h83);
    sc(18'h65, 1'b0);
    sc(18'h64, 1'b1);
    sc(18'h6D, 1'b1);
    sc(18'h6E, 1'b0);
    apb(1'b1, A_CFG, 32'h81);
    sc(18'h60, 1'b0);
    sc(18'h5F, 1'b1);
    sc(18'h69, 1'b0);
    // automatic mode with manual, user input and serial resets
    apb(1'b1, A_CFG, 32'h0);
    sc(18'h69, 1'b1);
    press(1'b1, 1'b0);
    out(0, 1'b0);
    sc(18'h6A, 1'b0);
    sc(18'h5A, 1'b0);
    sc(18'h69, 1'b1);
    press(1'b0, 1'b1);
    out(0, 1'b0);
    sc(18'h5A, 1'b0);
    sc(18'h69, 1'b1);
    apb(1'b1, 8'h38, 32'h1);
    repeat (3) @(negedge clk);
    out(0, 1'b0);
    // latching modes
    apb(1'b1, A_CFG, 32'h4);
    sc(18'h5A, 1'b0);
    sc(18'h69, 1'b1);
    sc(18'h5A, 1'b1);
    press(1'b1, 1'b0);
    out(0, 1'b0);
    sc(18'h69, 1'b1);
    press(1'b1, 1'b0);
    apb(1'b1, A_CFG, 32'h8);
    sc(18'h5A, 1'b0);
    sc(18'h69, 1'b1);
    press(1'b1, 1'b0);
    out(0, 1'b1);
    sc(18'h64, 1'b1);
    sc(18'h5F, 1'b0);
    // button as display reset, honoured only while the input is shown
    apb(1'b1, A_CFG, 32'h10);
    apb(1'b1, A_CTRL, 32'h16);
    sc(18'h69, 1'b1);
    press(1'b1, 1'b0);
    out(0, 1'b1);
    input_shown <= 1'b1;
    press(1'b1, 1'b0);
    out(0, 1'b0);
    // open probe forces the burn-out state
    apb(1'b1, A_CFG, 32'h40);
    sc(18'h5A, 1'b0);
    probe_open <= 1'b1;
    repeat (3) @(negedge clk);
    out(0, 1'b1);
    probe_open <= 1'b0;
    sc(18'h5A, 1'b0);
    // two second on and off delays at ten cycles a second
    apb(1'b1, A_CFG, 32'h0);
    apb(1'b1, A_TON, 32'h2);
    apb(1'b1, A_TOFF, 32'h2);
    smp(18'h69);
    dwait(1'b1, 9, 21);
    smp(18'h5A);
    dwait(1'b0, 9, 21);
    // second output enable and card presence
    apb(1'b1, A_VAL1, 32'h64);
    apb(1'b1, A_HYS1, 32'hA);
    fit <= 2'b11;
    apb(1'b1, A_CTRL, 32'h14);
    smp(18'h69);
    out(1, 1'b0);
    apb(1'b1, A_CTRL, 32'h15);
    smp(18'h5A);
    smp(18'h69);
    out(1, 1'b1);
    @(negedge clk);
    chk("load", 32'h2, 32'(load_on));
    fit <= 2'b00;
    repeat (3) @(negedge clk);
    chk("no card", 32'h0, 32'(sp_out));
    print_verdict();
  end
endmodule
`default_nettype wire
